// ===== hdl/ies_consts.svh
// Offsets, field positions, reset values and encodings of the execution subset
//
// Notes on behaviour
// - Accumulator clear: accumulator zero, null flag set
// - Subroutine jump pushes PC plus one on the edge that loads the target
// - Jump target: literal low, latch bits high
// - Subroutine jump: two cycles, flags untouched
// - Absolute branch: same target, no push, two cycles
// - Watchdog service zeroes counter and prescaler
// - Watchdog service sets expiry and sleep flags
// - Invert register, destination bit picks target
// - Decrement register, destination bit picks target
// - Increment register, only null flag changes
`ifndef IES_CONSTS_SVH
`define IES_CONSTS_SVH

// Register byte offsets
`define IES_OFF_INSTR 8'h00
`define IES_OFF_ACC 8'h04
`define IES_OFF_STATUS 8'h08
`define IES_OFF_PC 8'h0c
`define IES_OFF_ULATCH 8'h10
`define IES_OFF_FSEL 8'h14
`define IES_OFF_FDATA 8'h18
`define IES_OFF_WDOG 8'h1c
`define IES_OFF_STACK 8'h20

// Status register bit positions
`define IES_ST_ZERO 0
`define IES_ST_EXPIRY 1
`define IES_ST_SLEEP 2
`define IES_ST_BUSY 3

// Field positions inside the watchdog and stack read words
`define IES_HI_LSB 16

// Upper address latch bits that feed program counter bits 12:11
`define IES_ULA_HI 4
`define IES_ULA_LO 3

// Reset values
`define IES_RST_ACC 8'h00
`define IES_RST_PC 13'h0000
`define IES_RST_ULA 8'h00
`define IES_RST_ZERO 1'b0
`define IES_RST_EXPIRY 1'b1
`define IES_RST_SLEEP 1'b1

// Operation codes in bits 3:0 of the instruction word
`define IES_OPC_NOP 4'h0
`define IES_OPC_ACC_CLR 4'h1
`define IES_OPC_CALL 4'h2
`define IES_OPC_BRANCH 4'h3
`define IES_OPC_WDOG 4'h4
`define IES_OPC_INVERT 4'h5
`define IES_OPC_MINUS 4'h6
`define IES_OPC_PLUS 4'h7

// Execution state codes
`define IES_SC_IDLE 3'b001
`define IES_SC_EXEC 3'b010
`define IES_SC_SECOND 3'b100

`endif

// ===== hdl/ies_pkg.sv
// Types shared by the execution subset block
`include "ies_consts.svh"

package ies_pkg;

    typedef enum logic [3:0] {
        OP_NOP = `IES_OPC_NOP,
        OP_ACC_CLEAR = `IES_OPC_ACC_CLR,
        OP_CALL = `IES_OPC_CALL,
        OP_BRANCH = `IES_OPC_BRANCH,
        OP_WDOG = `IES_OPC_WDOG,
        OP_INVERT = `IES_OPC_INVERT,
        OP_MINUS = `IES_OPC_MINUS,
        OP_PLUS = `IES_OPC_PLUS
    } ies_op_type;

    typedef enum logic [2:0] {
        ST_IDLE = `IES_SC_IDLE,
        ST_EXEC = `IES_SC_EXEC,
        ST_SECOND = `IES_SC_SECOND
    } ies_state_type;

    // Instruction word as written to the issue register
    typedef struct packed {
        logic [4:0] pad_hi;
        logic [10:0] lit;
        logic [3:0] pad_mid;
        logic [6:0] faddr;
        logic dest;
        ies_op_type op;
    } ies_instr_type;

    // Captured AHB address phase
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } ies_dphase_type;

endpackage : ies_pkg

// ===== hdl/ies_ret_stack.sv
// Circular return-address stack with a registered head
`timescale 1ns/1ps
`default_nettype none

module ies_ret_stack #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 8,
    parameter int LVL_W = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic push,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] head,
    output logic [LVL_W-1:0] level
);

    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;

    // Overflow wraps and overwrites the oldest entry, as a hardware stack does
    always_ff @(posedge clk) begin
        if (ce && push) begin
            mem[wr_ptr_r] <= push_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_r <= '0;
            head <= '0;
            level <= '0;
        end else if (ce && push) begin
            wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            head <= push_data;
            if (level != LVL_W'(DEPTH)) begin
                level <= level + 1'b1;
            end
        end
    end

    a_push_head : assert property (@(posedge clk) disable iff (!rst_n)
        ce && push |=> head == $past(push_data) && mem[$past(wr_ptr_r)] == head)
        else $error("stack head does not hold the pushed word");

endmodule : ies_ret_stack

`default_nettype wire

// ===== hdl/ies_core.sv
// Execution logic for a small instruction subset behind an AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none

module ies_core
    import ies_pkg::*;
#(
    parameter int FILE_DEPTH = 128,
    parameter int STACK_DEPTH = 8,
    parameter int PRESC_W = 8,
    parameter int WDOG_W = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata
);

    localparam int LVL_W = $clog2(STACK_DEPTH + 1);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    ies_state_type state_r;
    ies_state_type state_nxt;
    ies_instr_type instr_r;
    ies_dphase_type dp_r;
    logic done_r;
    logic [31:0] hrdata_r;
    logic [7:0] acc_r;
    logic zero_r;
    logic expiry_r;
    logic sleep_r;
    logic [12:0] pc_r;
    logic [7:0] ula_r;
    logic [6:0] fsel_r;
    logic [7:0] file_mem [FILE_DEPTH];
    logic [PRESC_W-1:0] presc_r;
    logic [WDOG_W-1:0] wdog_r;
    logic [12:0] stack_head;
    logic [LVL_W-1:0] stack_level;
    logic [12:0] pc_plus1;
    logic [12:0] jump_target;
    logic [7:0] fval;
    logic [7:0] result_c;
    logic [31:0] rd_mux;
    logic addr_ok;
    logic busy;
    logic bus_act;
    logic wr_act;
    logic exec;
    logic is_jump;
    logic file_op;
    logic wdog_wrap;

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave

    assign addr_ok = hsel && htrans[1] && hready;
    assign busy = (state_r != ST_IDLE);
    // An access is carried out only between instructions, so it never races execution
    assign bus_act = dp_r.valid && !done_r && !busy;
    assign wr_act = bus_act && dp_r.write;
    // Every transfer takes at least one wait state, more while an instruction executes; low clock enable stalls the bus too
    assign hreadyout = ce && (!dp_r.valid || done_r);
    assign hresp = 1'b0;
    assign hrdata = hrdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_r <= '0;
            done_r <= 1'b0;
        end else if (ce) begin
            if (addr_ok) begin
                dp_r.valid <= 1'b1;
                dp_r.write <= hwrite;
                dp_r.addr <= haddr[7:0];
                done_r <= 1'b0;
            end else if (hready) begin
                dp_r.valid <= 1'b0;
                done_r <= 1'b0;
            end else if (bus_act) begin
                done_r <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (dp_r.addr)
            `IES_OFF_INSTR: rd_mux = instr_r;
            `IES_OFF_ACC: rd_mux = {24'h00_0000, acc_r};
            `IES_OFF_STATUS: begin
                rd_mux[`IES_ST_ZERO] = zero_r;
                rd_mux[`IES_ST_EXPIRY] = expiry_r;
                rd_mux[`IES_ST_SLEEP] = sleep_r;
                rd_mux[`IES_ST_BUSY] = busy;
            end
            `IES_OFF_PC: rd_mux = {19'h0_0000, pc_r};
            `IES_OFF_ULATCH: rd_mux = {24'h00_0000, ula_r};
            `IES_OFF_FSEL: rd_mux = {25'h000_0000, fsel_r};
            `IES_OFF_FDATA: rd_mux = {24'h00_0000, file_mem[fsel_r]};
            `IES_OFF_WDOG: rd_mux = 32'(presc_r) | (32'(wdog_r) << `IES_HI_LSB);
            `IES_OFF_STACK: rd_mux = 32'(stack_head) | (32'(stack_level) << `IES_HI_LSB);
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (ce && bus_act && !dp_r.write) begin
            hrdata_r <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Issue and sequencing

    assign exec = (state_r == ST_EXEC);
    assign is_jump = (instr_r.op == OP_CALL) || (instr_r.op == OP_BRANCH);
    assign file_op = (instr_r.op == OP_INVERT) || (instr_r.op == OP_MINUS) ||
                     (instr_r.op == OP_PLUS);

    always_comb begin
        case (state_r)
            ST_IDLE: state_nxt = ST_IDLE;
            ST_EXEC: state_nxt = is_jump ? ST_SECOND : ST_IDLE;
            ST_SECOND: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_IDLE;
            instr_r <= '0;
        end else if (ce) begin
            if (wr_act && dp_r.addr == `IES_OFF_INSTR) begin
                instr_r <= ies_instr_type'(hwdata);
                state_r <= ST_EXEC;
            end else begin
                state_r <= state_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Datapath

    assign pc_plus1 = pc_r + 13'h0001;
    assign jump_target = {ula_r[`IES_ULA_HI:`IES_ULA_LO], instr_r.lit};
    assign fval = file_mem[instr_r.faddr];

    always_comb begin
        case (instr_r.op)
            OP_INVERT: result_c = ~fval;
            OP_MINUS: result_c = fval - 8'h01;
            OP_PLUS: result_c = fval + 8'h01;
            default: result_c = fval;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= `IES_RST_ACC;
        end else if (ce) begin
            if (exec && instr_r.op == OP_ACC_CLEAR) begin
                acc_r <= 8'h00;
            end else if (exec && file_op && !instr_r.dest) begin
                acc_r <= result_c;
            end else if (wr_act && dp_r.addr == `IES_OFF_ACC) begin
                acc_r <= hwdata[7:0];
            end
        end
    end

    // Register file has no reset; its contents are data, not control
    always_ff @(posedge hclk) begin
        if (ce) begin
            if (exec && file_op && instr_r.dest) begin
                file_mem[instr_r.faddr] <= result_c;
            end else if (wr_act && dp_r.addr == `IES_OFF_FDATA) begin
                file_mem[fsel_r] <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fsel_r <= 7'h00;
            ula_r <= `IES_RST_ULA;
        end else if (ce && wr_act) begin
            if (dp_r.addr == `IES_OFF_FSEL) begin
                fsel_r <= hwdata[6:0];
            end
            if (dp_r.addr == `IES_OFF_ULATCH) begin
                ula_r <= hwdata[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pc_r <= `IES_RST_PC;
        end else if (ce) begin
            if (exec && is_jump) begin
                pc_r <= jump_target;
            end else if (exec) begin
                pc_r <= pc_plus1;
            end else if (wr_act && dp_r.addr == `IES_OFF_PC) begin
                pc_r <= hwdata[12:0];
            end
        end
    end

    // Push captures the old PC plus one in the same edge that loads the target
    ies_ret_stack #(
        .WIDTH(13),
        .DEPTH(STACK_DEPTH),
        .LVL_W(LVL_W)
    ) u_stack (
        .clk(hclk),
        .rst_n(hresetn),
        .ce(ce),
        .push(exec && instr_r.op == OP_CALL),
        .push_data(pc_plus1),
        .head(stack_head),
        .level(stack_level)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Status flags and watchdog

    // Jumps and watchdog service leave the null flag alone
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            zero_r <= `IES_RST_ZERO;
        end else if (ce) begin
            if (exec && instr_r.op == OP_ACC_CLEAR) begin
                zero_r <= 1'b1;
            end else if (exec && file_op) begin
                zero_r <= (result_c == 8'h00);
            end else if (wr_act && dp_r.addr == `IES_OFF_STATUS) begin
                zero_r <= hwdata[`IES_ST_ZERO];
            end
        end
    end

    assign wdog_wrap = (&presc_r) && (&wdog_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            presc_r <= '0;
            wdog_r <= '0;
        end else if (ce) begin
            if (exec && instr_r.op == OP_WDOG) begin
                presc_r <= '0;
                wdog_r <= '0;
            end else begin
                presc_r <= presc_r + 1'b1;
                if (&presc_r) begin
                    wdog_r <= wdog_r + 1'b1;
                end
            end
        end
    end

    // A hardware expiry wins over a software write in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            expiry_r <= `IES_RST_EXPIRY;
            sleep_r <= `IES_RST_SLEEP;
        end else if (ce) begin
            if (exec && instr_r.op == OP_WDOG) begin
                expiry_r <= 1'b1;
                sleep_r <= 1'b1;
            end else begin
                if (wdog_wrap) begin
                    expiry_r <= 1'b0;
                end else if (wr_act && dp_r.addr == `IES_OFF_STATUS) begin
                    expiry_r <= hwdata[`IES_ST_EXPIRY];
                end
                if (wr_act && dp_r.addr == `IES_OFF_STATUS) begin
                    sleep_r <= hwdata[`IES_ST_SLEEP];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_acc_clear_flags : assert property (
        ce && exec && instr_r.op == OP_ACC_CLEAR |=>
            acc_r == 8'h00 && zero_r && ($stable(expiry_r) || $past(wdog_wrap)) &&
            $stable(sleep_r))
        else $error("accumulator clear left a wrong value or flag");

    a_call_push_return : assert property (
        ce && exec && instr_r.op == OP_CALL |=>
            stack_head == $past(pc_r) + 13'h0001 && pc_r[10:0] == $past(instr_r.lit))
        else $error("call did not push the return address");

    a_call_target_load : assert property (
        ce && exec && instr_r.op == OP_CALL |=>
            pc_r[10:0] == $past(instr_r.lit) &&
            pc_r[12:11] == 2'($past(ula_r) >> `IES_ULA_LO))
        else $error("call target wrongly formed");

    a_jump_two_cycles : assert property (
        ce && exec && is_jump |=> state_r == ST_SECOND && $stable(zero_r) &&
            ($stable(expiry_r) || $past(wdog_wrap)) && $stable(sleep_r))
        else $error("jump did not take two cycles or touched flags");

    // Low enable freezes the second cycle, so only an enabled edge ends it
    a_jump_second_ends : assert property (
        ce && state_r == ST_SECOND |=> state_r == ST_IDLE)
        else $error("jump held its second cycle too long");

    a_branch_no_push : assert property (
        ce && exec && instr_r.op == OP_BRANCH |=>
            $stable(stack_level) && $stable(stack_head) && pc_r == $past(jump_target))
        else $error("branch pushed the stack or missed its target");

    a_wdog_clear_count : assert property (
        ce && exec && instr_r.op == OP_WDOG |=> wdog_r == '0 && presc_r == '0)
        else $error("watchdog service did not clear counter and prescaler");

    a_wdog_flags_set : assert property (
        ce && exec && instr_r.op == OP_WDOG |=> expiry_r && sleep_r && $stable(zero_r))
        else $error("watchdog service did not set both flags");

    a_file_result_route : assert property (
        ce && exec && file_op |=> (($past(instr_r.dest) ?
            file_mem[$past(instr_r.faddr)] : acc_r) == $past(result_c)))
        else $error("register operation result went to the wrong place");

    a_minus_value : assert property (
        ce && exec && instr_r.op == OP_MINUS && !instr_r.dest |=>
            acc_r == $past(fval) - 8'h01)
        else $error("decrement produced a wrong value");

    a_plus_flags_only : assert property (
        ce && exec && instr_r.op == OP_PLUS |=>
            ($stable(expiry_r) || $past(wdog_wrap)) && $stable(sleep_r) &&
            $stable(pc_r) == 1'b0)
        else $error("increment touched a flag other than null");

    a_single_cycle_null : assert property (
        ce && exec && !is_jump |=> state_r == ST_IDLE &&
            (!$past(file_op) || zero_r == ($past(result_c) == 8'h00)))
        else $error("single-cycle operation overran or null flag wrong");

    c_call_done : cover property (ce && exec && instr_r.op == OP_CALL ##2 state_r == ST_IDLE);
    c_wdog_service : cover property (ce && exec && instr_r.op == OP_WDOG);
    c_minus_to_zero : cover property (ce && exec && instr_r.op == OP_MINUS && result_c == 8'h00);
    c_read_done : cover property (dp_r.valid && !dp_r.write && hreadyout);

endmodule : ies_core

`default_nettype wire

// ===== verification/ies_core_tb.sv
// Self-checking bench for the execution subset block over its AHB-Lite port
`timescale 1ns/1ps
`default_nettype none
`include "ies_consts.svh"

module testbench
    import ies_pkg::*;
;
    logic hclk;
    logic hresetn;
    logic ce;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    int bad_count;
    int checks_done;
    logic [31:0] rd_val;
    logic [7:0] vals [6];
    logic [7:0] res;
    logic [7:0] p0;
    logic [7:0] gap;
    logic resp_seen;
    logic [6:0] fa;
    logic d;
    ies_op_type op;

    ies_core dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata)
    );

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        bad_count = 0;
        checks_done = 0;
    end

    always #10 hclk = ~hclk;

    task print_verdict;
        begin
            if (bad_count == 0 && checks_done > 0) begin
                $display("Test passed");
            end else begin
                $display("Test failed");
            end
            $finish;
        end
    endtask : print_verdict

    task check(input logic [31:0] seen, input logic [31:0] exp);
        begin
            checks_done++;
            if (seen !== exp) begin
                bad_count++;
                $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
            end
        end
    endtask : check

    // Ready is sampled on the settled value just before each rising edge
    task xfer(input logic wr, input logic [7:0] off, input logic [31:0] wd,
              output logic [31:0] rd);
        int n;
        logic rdy;
        begin
            n = 0;
            hsel <= 1'b1;
            htrans <= 2'b10;
            haddr <= {24'h00_0000, off};
            hwrite <= wr;
            do begin
                @(negedge hclk);
                rdy = hready;
                @(posedge hclk);
                n++;
            end while (rdy !== 1'b1 && n < 200);
            hsel <= 1'b0;
            htrans <= 2'b00;
            hwdata <= wd;
            do begin
                @(negedge hclk);
                rdy = hready;
                rd = hrdata;
                resp_seen = hresp;
                @(posedge hclk);
                n++;
            end while (rdy !== 1'b1 && n < 400);
            if (rdy !== 1'b1) begin
                bad_count++;
                $display("CHECK FAILED at %0t: bus never answered", $time);
            end
        end
    endtask : xfer

    task wr(input logic [7:0] off, input logic [31:0] wd);
        logic [31:0] dummy;
        begin
            xfer(1'b1, off, wd, dummy);
        end
    endtask : wr

    task rd_reg(input logic [7:0] off);
        begin
            xfer(1'b0, off, 32'h0000_0000, rd_val);
        end
    endtask : rd_reg

    function automatic logic [31:0] mk(ies_op_type o, logic dst, logic [6:0] a,
                                       logic [10:0] k);
        ies_instr_type ins;
        ins = '0;
        ins.op = o;
        ins.dest = dst;
        ins.faddr = a;
        ins.lit = k;
        return ins;
    endfunction : mk

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        bad_count++;
        print_verdict();
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        vals = '{8'hff, 8'h5a, 8'h01, 8'h00, 8'hff, 8'h7f};
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_reg(`IES_OFF_STATUS);
        check(rd_val, 32'h0000_0006);
        check({31'h0, resp_seen}, 32'h0000_0000);
        rd_reg(`IES_OFF_STACK);
        check(rd_val, 32'h0000_0000);
        // Unmapped and read-only places ignore writes
        wr(8'h40, 32'hffff_ffff);
        rd_reg(8'h40);
        check(rd_val, 32'h0000_0000);
        wr(`IES_OFF_STACK, 32'h0000_1234);
        rd_reg(`IES_OFF_STACK);
        check(rd_val, 32'h0000_0000);

        // Accumulator clear keeps expiry and sleep as they were
        wr(`IES_OFF_ACC, 32'h0000_005a);
        wr(`IES_OFF_STATUS, 32'h0000_0004);
        wr(`IES_OFF_INSTR, mk(OP_ACC_CLEAR, 1'b0, 7'h00, 11'h000));
        rd_reg(`IES_OFF_ACC);
        check(rd_val, 32'h0000_0000);
        rd_reg(`IES_OFF_STATUS);
        check(rd_val, 32'h0000_0005);

        // Subroutine jump from the top literal, both latch bits set
        wr(`IES_OFF_PC, 32'h0000_0123);
        wr(`IES_OFF_ULATCH, 32'h0000_00f8);
        wr(`IES_OFF_STATUS, 32'h0000_0002);
        wr(`IES_OFF_INSTR, mk(OP_CALL, 1'b0, 7'h00, 11'h7ff));
        rd_reg(`IES_OFF_PC);
        check(rd_val, 32'h0000_1fff);
        rd_reg(`IES_OFF_STACK);
        check(rd_val, 32'h0001_0124);
        rd_reg(`IES_OFF_STATUS);
        check(rd_val, 32'h0000_0002);
        // Second jump back to back, only latch bit 3 set
        wr(`IES_OFF_ULATCH, 32'h0000_0008);
        wr(`IES_OFF_INSTR, mk(OP_CALL, 1'b0, 7'h00, 11'h000));
        rd_reg(`IES_OFF_PC);
        check(rd_val, 32'h0000_0800);
        rd_reg(`IES_OFF_STACK);
        check(rd_val, 32'h0002_0000);

        // Absolute branch leaves the stack alone
        wr(`IES_OFF_PC, 32'h0000_0500);
        wr(`IES_OFF_ULATCH, 32'h0000_0010);
        wr(`IES_OFF_STATUS, 32'h0000_0005);
        wr(`IES_OFF_INSTR, mk(OP_BRANCH, 1'b1, 7'h7f, 11'h2aa));
        rd_reg(`IES_OFF_PC);
        check(rd_val, 32'h0000_12aa);
        rd_reg(`IES_OFF_STACK);
        check(rd_val, 32'h0002_0000);
        rd_reg(`IES_OFF_STATUS);
        check(rd_val, 32'h0000_0005);

        // Let the watchdog count up before servicing it
        repeat (300) @(posedge hclk);
        rd_reg(`IES_OFF_WDOG);
        check({31'h0, rd_val[23:16] != 8'h00}, 32'h0000_0001);
        // Low enable freezes the prescaler, so a stalled gap counts the same
        p0 = rd_val[7:0];
        rd_reg(`IES_OFF_WDOG);
        gap = rd_val[7:0] - p0;
        p0 = rd_val[7:0];
        ce <= 1'b0;
        repeat (20) @(posedge hclk);
        ce <= 1'b1;
        rd_reg(`IES_OFF_WDOG);
        check({24'h0, rd_val[7:0] - p0}, {24'h0, gap});
        wr(`IES_OFF_STATUS, 32'h0000_0000);
        wr(`IES_OFF_INSTR, mk(OP_WDOG, 1'b0, 7'h00, 11'h000));
        rd_reg(`IES_OFF_WDOG);
        check({rd_val[31:8], 8'h00}, 32'h0000_0000);
        check({31'h0, rd_val[7:0] < 8'h10}, 32'h0000_0001);
        rd_reg(`IES_OFF_STATUS);
        check(rd_val, 32'h0000_0006);

        // File ops, each destination, with zero and wrap boundaries
        for (int i = 0; i < 6; i++) begin
            op = (i < 2) ? OP_INVERT : ((i < 4) ? OP_MINUS : OP_PLUS);
            d = i[0];
            fa = (i == 5) ? 7'h7f : 7'(i * 20);
            res = (i < 2) ? ~vals[i] : ((i < 4) ? vals[i] - 8'h01 : vals[i] + 8'h01);
            wr(`IES_OFF_FSEL, {25'h0, fa});
            wr(`IES_OFF_FDATA, {24'h0, vals[i]});
            wr(`IES_OFF_ACC, 32'h0000_0033);
            wr(`IES_OFF_PC, 32'h0000_0100);
            // Null flag preset opposite to the expected one, so a stale flag shows
            wr(`IES_OFF_STATUS, {29'h0, 3'h4} | {31'h0, res != 8'h00});
            wr(`IES_OFF_INSTR, mk(op, d, fa, 11'h000));
            rd_reg(`IES_OFF_ACC);
            check(rd_val, {24'h0, d ? 8'h33 : res});
            rd_reg(`IES_OFF_FDATA);
            check(rd_val, {24'h0, d ? res : vals[i]});
            rd_reg(`IES_OFF_STATUS);
            check(rd_val, {29'h0, 3'h4} | {31'h0, res == 8'h00});
            rd_reg(`IES_OFF_PC);
            check(rd_val, 32'h0000_0101);
        end
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
